// ### shared/hp_misc_cfg_defs.vh
// constants for the hot plug miscellaneous configuration register
`ifndef HP_MISC_CFG_DEFS_VH
`define HP_MISC_CFG_DEFS_VH
`define CFG_MISC_OFFSET      8'h42
`define CFG_INDEX_OFFSET     8'h50
`define CFG_DATA_OFFSET      8'h54
`define MEM_MISC_OFFSET      8'h02
`define BIT_CHANGE_ID        15
`define BIT_INHIBIT          14
`define BIT_PF_ENABLE        13
`define BIT_APD_LOCK         12
`define BIT_CFG_ACCESS       7
`define BIT_DUMMY_CYCLE      6
`define BIT_BUS_MODE         5
`define MEM_BIT_PF_ENABLE    10
`define MEM_BIT_APD_DISABLE  0
`define MISC_RESET           16'h0000
`define SLOT_COUNT           2
`endif

// ### core/wonce_bit.v
// write-once storage bit cleared only by reset
`timescale 1ns/10ps
module wonce_bit (
   input  wire CLK,
   input  wire ARST_N,
   input  wire wr,
   input  wire din,
   output reg  q
);
   reg done_q;
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         q      <= 1'b0;
         done_q <= 1'b0;
      end else if (wr && !done_q) begin
         q      <= din;
         done_q <= 1'b1;
      end
   end
endmodule // wonce_bit

// ### core/hotplug_misc_config_reg.v
// hot plug miscellaneous configuration register with memory-space gating
// What this block does
// - the change-identifier bit is write-once, resets to 0 and does nothing.
// - power-fault error reporting and latch scanning happen only while the enable bit is 1.
// - the power-fault enable bit is one storage seen at config 42h bit 13 and memory 02h bit 10.
// - in parallel modes a slot power fault disconnects bus, clock, power and asserts slot reset.
// - writing the power-fault enable bit to 0 clears all power-fault latches.
// - while the lock bit is 1 the memory auto-power-down disable bit ignores writes.
// - while the access enable bit is 1, memory registers are reached via index 50h and data 54h.
// - the dummy-cycle enable bit is plain storage resetting to 0.
// - bit 5 reads the current PCI-X bus mode.
`timescale 1ns/10ps
`include "hp_misc_cfg_defs.vh"
module hotplug_misc_config_reg (
   input  wire        CLK,
   input  wire        ARST_N,
   input  wire        CFG_WR,
   input  wire        CFG_RD,
   input  wire [7:0]  CFG_ADDR,
   input  wire [3:0]  CFG_BE,
   input  wire [31:0] CFG_WDATA,
   output reg  [31:0] CFG_RDATA,
   input  wire        MEM_WR,
   input  wire        MEM_RD,
   input  wire [7:0]  MEM_ADDR,
   input  wire [31:0] MEM_WDATA,
   output reg  [31:0] MEM_RDATA,
   input  wire        BUS_MODE,
   input  wire        PARALLEL_MODE,
   input  wire [1:0]  POWER_FAULT,
   output reg         SERR_PF,
   output reg  [1:0]  PF_LATCH,
   output reg  [1:0]  SLOT_DISCONNECT,
   output reg  [1:0]  SLOT_RESET_OUTPUT_N,
   output reg         APD_DISABLE
);
   reg         pf_enable_q;
   reg         dummy_cycle_q;
   reg         cfg_access_q;
   reg  [7:0]  index_q;
   reg  [31:0] mem_mirror_q;
   reg  [1:0]  latch_q;
   wire        change_id;
   wire        inhibit;
   wire        apd_lock;
   wire        mode_now;
   wire        hi_wr;
   wire        lo_wr;
   wire        cfg_ind_wr;
   wire        cfg_ind_rd;
   wire        m_wr;
   wire        m_rd;
   wire [7:0]  m_addr;
   wire [31:0] m_wdata;
   wire [15:0] misc_val;
   wire [1:0]  new_fault;
   wire        m_misc_wr;
   wire [1:0]  fault_seen;

   // dword decode of the misc register, which sits in the upper half of 40h
   function misc_hit;
      input [7:0] addr;
      begin
         misc_hit = ((addr & 8'hFC) == (`CFG_MISC_OFFSET & 8'hFC));
      end
   endfunction

   // memory misc word as read, enable and disable bits from their own storage
   function [31:0] mem_view;
      input [31:0] mirror;
      input        pf;
      input        apd;
      begin
         mem_view = {mirror[31:11], pf, mirror[9:1], apd};
      end
   endfunction

   assign mode_now   = BUS_MODE;
   assign hi_wr      = CFG_WR && misc_hit(CFG_ADDR) && CFG_BE[3];
   assign lo_wr      = CFG_WR && misc_hit(CFG_ADDR) && CFG_BE[2];
   assign m_misc_wr  = m_wr && (m_addr == `MEM_MISC_OFFSET);
   assign cfg_ind_wr = CFG_WR && cfg_access_q && (CFG_ADDR == `CFG_DATA_OFFSET);
   assign cfg_ind_rd = CFG_RD && cfg_access_q && (CFG_ADDR == `CFG_DATA_OFFSET);
   assign m_wr       = (MEM_WR || cfg_ind_wr) && !inhibit;
   assign m_rd       = (MEM_RD || cfg_ind_rd) && !inhibit;
   assign m_addr     = cfg_ind_wr || cfg_ind_rd ? index_q : MEM_ADDR;
   assign m_wdata    = cfg_ind_wr ? CFG_WDATA : MEM_WDATA;
   assign misc_val   = {change_id, inhibit, pf_enable_q, apd_lock, 4'h0,
                        cfg_access_q, dummy_cycle_q, mode_now, 5'h00};
   assign new_fault  = POWER_FAULT & {2{pf_enable_q}};
   assign fault_seen = latch_q | new_fault;

   wonce_bit u_change_id (
      .CLK    (CLK),
      .ARST_N (ARST_N),
      .wr     (hi_wr),
      .din    (CFG_WDATA[16+`BIT_CHANGE_ID]),
      .q      (change_id)
   );
   wonce_bit u_inhibit (
      .CLK    (CLK),
      .ARST_N (ARST_N),
      .wr     (hi_wr),
      .din    (CFG_WDATA[16+`BIT_INHIBIT]),
      .q      (inhibit)
   );
   wonce_bit u_apd_lock (
      .CLK    (CLK),
      .ARST_N (ARST_N),
      .wr     (hi_wr),
      .din    (CFG_WDATA[16+`BIT_APD_LOCK]),
      .q      (apd_lock)
   );

   // one storage for the enable bit from both spaces; config wins on a clash
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pf_enable_q <= 1'b0;
      end else if (hi_wr) begin
         pf_enable_q <= CFG_WDATA[16+`BIT_PF_ENABLE];
      end else if (m_misc_wr) begin
         pf_enable_q <= m_wdata[`MEM_BIT_PF_ENABLE];
      end
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg_access_q  <= 1'b0;
         dummy_cycle_q <= 1'b0;
      end else if (lo_wr) begin
         cfg_access_q  <= CFG_WDATA[16+`BIT_CFG_ACCESS];
         dummy_cycle_q <= CFG_WDATA[16+`BIT_DUMMY_CYCLE];
      end
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         index_q <= 8'h00;
      end else if (CFG_WR && cfg_access_q && CFG_ADDR == `CFG_INDEX_OFFSET) begin
         index_q <= CFG_WDATA[7:0];
      end
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mem_mirror_q <= 32'h00000000;
      end else if (m_misc_wr) begin
         mem_mirror_q <= m_wdata;
      end
   end

   // the lock freezes the disable bit against every later write
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         APD_DISABLE <= 1'b0;
      end else if (m_misc_wr && !apd_lock) begin
         APD_DISABLE <= m_wdata[`MEM_BIT_APD_DISABLE];
      end
   end

   // a disabling config write clears at once, a memory disable one cycle later
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         latch_q <= 2'b00;
      end else if ((hi_wr && !CFG_WDATA[16+`BIT_PF_ENABLE]) || !pf_enable_q) begin
         latch_q <= 2'b00;
      end else begin
         latch_q <= fault_seen;
      end
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PF_LATCH <= 2'b00;
         SERR_PF  <= 1'b0;
      end else begin
         PF_LATCH <= latch_q;
         SERR_PF  <= |new_fault;
      end
   end

   // parallel modes cut the slot here; serial modes leave it to board logic
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SLOT_DISCONNECT     <= 2'b00;
         SLOT_RESET_OUTPUT_N <= 2'b00;
      end else if (PARALLEL_MODE) begin
         SLOT_DISCONNECT     <= fault_seen;
         SLOT_RESET_OUTPUT_N <= ~fault_seen;
      end else begin
         SLOT_DISCONNECT     <= 2'b00;
         SLOT_RESET_OUTPUT_N <= 2'b11;
      end
   end

   // config read data stands one cycle after the strobe, zero otherwise
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CFG_RDATA <= 32'h00000000;
      end else if (CFG_RD && misc_hit(CFG_ADDR)) begin
         CFG_RDATA <= {misc_val, 16'h0000};
      end else if (CFG_RD && cfg_access_q && CFG_ADDR == `CFG_INDEX_OFFSET) begin
         CFG_RDATA <= {24'h000000, index_q};
      end else if (cfg_ind_rd && m_rd && index_q == `MEM_MISC_OFFSET) begin
         CFG_RDATA <= mem_view(mem_mirror_q, pf_enable_q, APD_DISABLE);
      end else begin
         CFG_RDATA <= 32'h00000000;
      end
   end

   // memory reads give zero while inhibited and for unbacked offsets
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         MEM_RDATA <= 32'h00000000;
      end else if (MEM_RD && m_rd && MEM_ADDR == `MEM_MISC_OFFSET) begin
         MEM_RDATA <= mem_view(mem_mirror_q, pf_enable_q, APD_DISABLE);
      end else begin
         MEM_RDATA <= 32'h00000000;
      end
   end
endmodule // hotplug_misc_config_reg

// ### test/hotplug_misc_config_reg_chk.sv
// assertions on the ports of the hot plug misc config register
`timescale 1ns/10ps
module hotplug_misc_config_reg_chk (
   input wire        CLK,
   input wire        ARST_N,
   input wire        CFG_WR,
   input wire        CFG_RD,
   input wire [7:0]  CFG_ADDR,
   input wire [3:0]  CFG_BE,
   input wire [31:0] CFG_WDATA,
   input wire [31:0] CFG_RDATA,
   input wire        MEM_WR,
   input wire [7:0]  MEM_ADDR,
   input wire [31:0] MEM_WDATA,
   input wire        BUS_MODE,
   input wire        PARALLEL_MODE,
   input wire [1:0]  POWER_FAULT,
   input wire        SERR_PF,
   input wire [1:0]  PF_LATCH,
   input wire [1:0]  SLOT_DISCONNECT,
   input wire [1:0]  SLOT_RESET_OUTPUT_N,
   input wire        APD_DISABLE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   chk_rsvd_read_zero:
   assert property ($past(CFG_RD && CFG_ADDR == 8'h40) |-> CFG_RDATA[27:24] == 4'h0)
      else $error("reserved bits not zero");
   chk_mode_bit_read:
   assert property ($past(CFG_RD && CFG_ADDR == 8'h40) |-> CFG_RDATA[21] == $past(BUS_MODE))
      else $error("bus mode bit wrong");
   chk_rdata_idle_zero:
   assert property (!$past(CFG_RD) |-> CFG_RDATA == 32'h0)
      else $error("read data not zero when idle");
   chk_cfg_pf_clear:
   assert property (CFG_WR && CFG_ADDR == 8'h40 && CFG_BE[3] && !CFG_WDATA[29]
      |-> ##2 PF_LATCH == 2'h0 && !SERR_PF) else $error("latches kept after disable");
   chk_mem_pf_clear:
   assert property (MEM_WR && MEM_ADDR == 8'h02 && !MEM_WDATA[10] |-> ##3 PF_LATCH == 2'h0)
      else $error("latches kept after memory disable");
   chk_disc_cause:
   assert property ($rose(SLOT_DISCONNECT[0])
      |-> $past(PARALLEL_MODE) && ($past(POWER_FAULT[0]) || PF_LATCH[0]))
      else $error("disconnect without parallel fault");
   chk_disc_reset:
   assert property ((SLOT_DISCONNECT & SLOT_RESET_OUTPUT_N) == 2'h0)
      else $error("disconnected slot not in reset");
   chk_apd_cause:
   assert property ($changed(APD_DISABLE)
      |-> $past(MEM_WR && MEM_ADDR == 8'h02 || CFG_WR && CFG_ADDR == 8'h54))
      else $error("auto power down bit changed alone");
endmodule // hotplug_misc_config_reg_chk
bind hotplug_misc_config_reg hotplug_misc_config_reg_chk u_chk (.*);

// ### test/hotplug_misc_config_reg_tb.sv
// self-checking bench for the hot plug misc config register
`timescale 1ns/10ps
module hotplug_misc_config_reg_tb;
   reg         CLK = 0, ARST_N = 0, CFG_WR = 0, CFG_RD = 0, MEM_WR = 0, MEM_RD = 0;
   reg         BUS_MODE = 0, PARALLEL_MODE = 1;
   reg  [7:0]  CFG_ADDR = 0, MEM_ADDR = 0;
   reg  [3:0]  CFG_BE = 0;
   reg  [31:0] CFG_WDATA = 0, MEM_WDATA = 0, d;
   reg  [1:0]  POWER_FAULT = 0;
   reg  [16:0] seed = 17'd67506;
   wire [31:0] CFG_RDATA, MEM_RDATA;
   wire        SERR_PF, APD_DISABLE;
   wire [1:0]  PF_LATCH, SLOT_DISCONNECT, SLOT_RESET_OUTPUT_N;
   integer     miscompares = 0, check_count = 0, cyc = 0, i;
   localparam [31:0] M = 32'hFFE00000;
   hotplug_misc_config_reg u_dut (.*);
   function [16:0] lfsr(input [16:0] s);
      lfsr = {s[15:0], s[16] ^ s[13]};
   endfunction
   function [31:0] ex(input [15:0] v);
      ex = {(v & 16'hF0C0) | {10'h0, BUS_MODE, 5'h0}, 16'h0};
   endfunction
   task chk(input [31:0] g, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task print_verdict;
      if (miscompares == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task rst;
      begin
         ARST_N = 0;
         repeat (4) @(negedge CLK);
         ARST_N = 1;
      end
   endtask
   task wr(input m, input [7:0] a, input [31:0] v);
      begin
         @(negedge CLK);
         {MEM_WR, CFG_WR} = {m, !m};
         {MEM_ADDR, CFG_ADDR, CFG_BE} = {a, a, 4'hC};
         {MEM_WDATA, CFG_WDATA} = {v, v};
         @(negedge CLK);
         {MEM_WR, CFG_WR} = 2'h0;
      end
   endtask
   task rd(input m, input [7:0] a);
      begin
         @(negedge CLK);
         {MEM_RD, CFG_RD, MEM_ADDR, CFG_ADDR} = {m, !m, a, a};
         @(negedge CLK);
         d = m ? MEM_RDATA : CFG_RDATA;
         {MEM_RD, CFG_RD} = 2'h0;
      end
   endtask
   initial forever #5 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         miscompares = miscompares + 1;
         print_verdict;
      end
   end
   initial begin
      rst;
      rd(0, 8'h40);
      chk(d & M, ex(16'h0));
      wr(0, 8'h40, 32'hBFC00000);
      rd(0, 8'h40);
      chk(d & M, ex(16'hB0C0));
      wr(1, 8'h02, 32'h401);
      rd(1, 8'h02);
      chk({d[10], 30'h0, APD_DISABLE}, 32'h80000000);
      wr(0, 8'h50, 32'h2);
      rd(0, 8'h50);
      chk(d, 32'h2);
      rd(0, 8'h54);
      chk(d, 32'h400);
      POWER_FAULT = 2'h1;
      repeat (3) @(negedge CLK);
      chk({25'h0, SERR_PF, PF_LATCH, SLOT_DISCONNECT, SLOT_RESET_OUTPUT_N}, 32'h56);
      POWER_FAULT = 2'h0;
      wr(1, 8'h02, 32'h0);
      rd(0, 8'h40);
      chk(d & M | PF_LATCH, ex(16'h90C0));
      wr(0, 8'h40, 32'h60000000);
      rd(0, 8'h40);
      chk(d & M, ex(16'hB000));
      for (i = 0; i < 300; i = i + 1) begin
         seed = lfsr(seed);
         {BUS_MODE, PARALLEL_MODE, POWER_FAULT} = seed[3:0];
         rd(0, 8'h40);
         chk(d & 32'h200000, ex(16'h0) & 32'h200000);
      end
      POWER_FAULT = 2'h0;
      rst;
      wr(1, 8'h02, 32'h1);
      chk({31'h0, APD_DISABLE}, 32'h1);
      wr(0, 8'h40, 32'h40000000);
      wr(1, 8'h02, 32'h0);
      rd(1, 8'h02);
      chk(d, 32'h0);
      chk({31'h0, APD_DISABLE}, 32'h1);
      rd(0, 8'h40);
      chk(d & M, ex(16'h4000));
      print_verdict;
   end
endmodule // hotplug_misc_config_reg_tb
